// >>> core/mrc_regs.svh
// Contract
// - overload time counts at reference load 180% (<=200 W) or 150% (larger drives).
// - overload time 0.1..40.0 s, default 30.0 s, applies at once.
// - power-on start guard defaults enabled; active run input at power-up ignored.
// - guard at 0 with run input held lets motor start right after power-up.
// - motor stops when run input drops or power is removed.
// - with no data number selected, speed of entry zero is used.
// - stop-holding gives about 50% rated torque at standstill; lost without power.
// - stop-holding defaults off; change applies only after configuration executes.
// - holding force starts once shaft is displaced about 15 degrees.
// - torque limit of 50% or less caps the holding torque.
// - time unit 0 reads ramp times per 3000 r/min.
// - time unit 1 with digital speed reads ramp times to commanded speed.
// - time unit selection ignored in input modes 3 and 5.
// - softening filter 0 none, 1, 2; takes effect only after motor stops.
// - input mode field has six codes, default 0, applies after configuration.
// - each 2-wire mode defines response to forward and reverse both on.
// - each 3-wire mode defines response to direction select change.
// - 3-wire: forward is start/stop, reverse is run/brake, stop-mode is direction.
// - speed-reached asserted while running forward or reverse and speed within plus/minus width of command.
// - detection width 1..400 r/min, default 200, applies at once.
`ifndef MRC_REGS_SVH
`define MRC_REGS_SVH
`define MRC_ADDR_CTRL       12'h000
`define MRC_ADDR_OVL_TIME   12'h004
`define MRC_ADDR_VA_WIDTH   12'h008
`define MRC_ADDR_CFG_EXEC   12'h00C
`define MRC_ADDR_SPEED0     12'h010
`define MRC_ADDR_SPEED_SEL  12'h014
`define MRC_ADDR_STATUS     12'h018
`define MRC_ADDR_ACT_SPEED  12'h01C
`define MRC_ADDR_EFF_CFG    12'h020
`define MRC_ADDR_TORQUE     12'h024
`define MRC_CTRL_GUARD_BIT  0
`define MRC_CTRL_HOLD_BIT   1
`define MRC_CTRL_UNIT_BIT   2
`define MRC_CTRL_FILT_LSB   4
`define MRC_CTRL_MODE_LSB   8
`define MRC_CTRL_RST        32'h0000_0001
`define MRC_OVL_MIN         16'd1
`define MRC_OVL_MAX         16'd400
`define MRC_OVL_RST         16'd300
`define MRC_VA_MIN          16'd1
`define MRC_VA_MAX          16'd400
`define MRC_VA_RST          16'd200
`define MRC_RATED_RPM       16'd3000
`define MRC_REF_LOAD_SMALL  16'd180
`define MRC_REF_LOAD_LARGE  16'd150
`define MRC_HOLD_PCT        8'd50
`define MRC_HOLD_DEG10      16'd150
`define MRC_TENTH_NS        100000000
`define MRC_CLK_NS          5
`define MRC_TENTH_CYC       (`MRC_TENTH_NS / `MRC_CLK_NS)
`endif

// >>> core/mrc_pkg.sv
package mrc_pkg;
  typedef enum logic [2:0] {
    MRC_2W1 = 3'b000,
    MRC_3W1 = 3'b001,
    MRC_2W2 = 3'b010,
    MRC_2W3 = 3'b011,
    MRC_3W2 = 3'b100,
    MRC_3W3 = 3'b101
  } mrc_mode_t;
  typedef enum logic [1:0] {
    MRC_ST_STOP = 2'b00,
    MRC_ST_FWD  = 2'b01,
    MRC_ST_REV  = 2'b10,
    MRC_ST_BRK  = 2'b11
  } mrc_state_t;
  typedef enum logic [1:0] {
    MRC_FILT_NONE = 2'b00,
    MRC_FILT_1    = 2'b01,
    MRC_FILT_2    = 2'b10
  } mrc_filt_t;
endpackage

// >>> core/mrc_run_ctrl.sv
`timescale 1ns/1ps
`include "mrc_regs.svh"
module mrc_run_ctrl #(
  parameter int unsigned TENTH_CYC = `MRC_TENTH_CYC,
  parameter bit          SMALL_DRV = 1'b1
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  // apb slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // run inputs from pins
  input  wire logic                 forward_run_input_i,
  input  wire logic                 reverse_run_input_i,
  input  wire logic                 direction_select_input_i,
  // power stage feedback
  input  wire logic [15:0]          act_speed_i,
  input  wire logic [15:0]          load_pct_i,
  input  wire logic [15:0]          shaft_disp_i,
  input  wire logic [7:0]           torque_limit_i,
  // power stage commands
  output mrc_pkg::mrc_state_t       run_state_o,
  output logic [15:0]               cmd_speed_o,
  output logic                      unit_per_cmd_o,
  output mrc_pkg::mrc_filt_t        filter_sel_o,
  output logic [7:0]                hold_torque_o,
  output logic                      overload_alarm_o,
  output logic                      guard_alarm_o,
  output logic                      speed_reached_output_o
);
  import mrc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {direction_select_input_i, reverse_run_input_i, forward_run_input_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  logic fwd_in;
  logic rev_in;
  logic dir_in;
  assign fwd_in = pin_s2_ff[0];
  assign rev_in = pin_s2_ff[1];
  assign dir_in = pin_s2_ff[2];

  ////////////////////////////////////////////////////////////////
  // apb registers
  logic [31:0] ctrl_ff;
  logic [15:0] ovl_time_ff;
  logic [15:0] va_width_ff;
  logic [15:0] speed0_ff;
  logic [15:0] speed_sel_ff;
  logic        wr_en;
  logic        cfg_exec;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign cfg_exec  = wr_en & (paddr_i == `MRC_ADDR_CFG_EXEC) & pwdata_i[0];
  assign pready_o  = 1'b1;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff      <= `MRC_CTRL_RST;
      ovl_time_ff  <= `MRC_OVL_RST;
      va_width_ff  <= `MRC_VA_RST;
      speed0_ff    <= 16'h0000;
      speed_sel_ff <= 16'h0000;
    end else if (wr_en) begin
      unique case (paddr_i)
        `MRC_ADDR_CTRL: begin
          ctrl_ff <= pwdata_i & 32'h0000_0737;
        end
        `MRC_ADDR_OVL_TIME: begin
          if (pwdata_i[15:0] >= `MRC_OVL_MIN && pwdata_i[15:0] <= `MRC_OVL_MAX) begin
            ovl_time_ff <= pwdata_i[15:0];
          end
        end
        `MRC_ADDR_VA_WIDTH: begin
          if (pwdata_i[15:0] >= `MRC_VA_MIN && pwdata_i[15:0] <= `MRC_VA_MAX) begin
            va_width_ff <= pwdata_i[15:0];
          end
        end
        `MRC_ADDR_SPEED0: begin
          speed0_ff <= pwdata_i[15:0];
        end
        `MRC_ADDR_SPEED_SEL: begin
          speed_sel_ff <= pwdata_i[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  logic addr_ok;
  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr_i)
      `MRC_ADDR_CTRL, `MRC_ADDR_OVL_TIME, `MRC_ADDR_VA_WIDTH, `MRC_ADDR_CFG_EXEC, `MRC_ADDR_SPEED0,
      `MRC_ADDR_SPEED_SEL, `MRC_ADDR_STATUS, `MRC_ADDR_ACT_SPEED, `MRC_ADDR_EFF_CFG,
      `MRC_ADDR_TORQUE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i & penable_i & ~addr_ok;

  ////////////////////////////////////////////////////////////////
  // configured values: hold and mode on config execute, filter at stop
  logic       hold_en_ff;
  mrc_mode_t  mode_ff;
  mrc_filt_t  filt_ff;
  mrc_state_t state_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_en_ff <= 1'b0;
      mode_ff    <= MRC_2W1;
    end else if (cfg_exec) begin
      hold_en_ff <= ctrl_ff[`MRC_CTRL_HOLD_BIT];
      if (ctrl_ff[`MRC_CTRL_MODE_LSB+:3] <= 3'h5) begin
        mode_ff <= mrc_mode_t'(ctrl_ff[`MRC_CTRL_MODE_LSB+:3]);
      end
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      filt_ff <= MRC_FILT_NONE;
    end else if (state_ff == MRC_ST_STOP && ctrl_ff[`MRC_CTRL_FILT_LSB+:2] != 2'h3) begin
      filt_ff <= mrc_filt_t'(ctrl_ff[`MRC_CTRL_FILT_LSB+:2]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // power-on start guard: decided once the synced pins are valid
  logic [2:0] arm_cnt_ff;
  logic       arming;
  logic       guard_hit;
  logic       guard_ff;
  logic       run_req;
  assign arming    = arm_cnt_ff != 3'h4;
  assign guard_hit = (arm_cnt_ff == 3'h3) && run_req && ctrl_ff[`MRC_CTRL_GUARD_BIT];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arm_cnt_ff <= 3'h0;
      guard_ff   <= 1'b0;
    end else begin
      if (arming) begin
        arm_cnt_ff <= arm_cnt_ff + 3'h1;
      end
      if (guard_hit) begin
        guard_ff <= 1'b1;
      end else if (!run_req) begin
        guard_ff <= 1'b0;
      end
    end
  end
  assign guard_alarm_o = guard_ff;

  ////////////////////////////////////////////////////////////////
  // run decode per input mode
  logic is_3w;
  assign is_3w = (mode_ff == MRC_3W1) || (mode_ff == MRC_3W2) || (mode_ff == MRC_3W3);
  assign run_req = is_3w ? fwd_in : (fwd_in | rev_in);
  logic       dir_q_ff;
  logic       first_ff;
  logic       dir_hold_ff;
  logic       dir_hit;
  mrc_state_t nxt_state;
  // direction change that stops or brakes until start is released
  assign dir_hit = is_3w && fwd_in && rev_in && (dir_in != dir_q_ff) && (state_ff != MRC_ST_STOP)
                   && (mode_ff == MRC_3W2 || mode_ff == MRC_3W3);
  always_comb begin
    nxt_state = MRC_ST_STOP;
    if (arming || guard_hit || guard_ff || overload_alarm_o) begin
      nxt_state = MRC_ST_STOP;
    end else if (is_3w) begin
      if (!fwd_in) begin
        nxt_state = MRC_ST_STOP;
      end else if (!rev_in) begin
        nxt_state = MRC_ST_BRK;
      end else if (dir_hold_ff) begin
        nxt_state = (mode_ff == MRC_3W3) ? MRC_ST_BRK : MRC_ST_STOP;
      end else if (dir_in != dir_q_ff && state_ff != MRC_ST_STOP) begin
        unique case (mode_ff)
          MRC_3W2: nxt_state = MRC_ST_STOP;
          MRC_3W3: nxt_state = MRC_ST_BRK;
          default: nxt_state = dir_in ? MRC_ST_REV : MRC_ST_FWD;
        endcase
      end else begin
        nxt_state = dir_in ? MRC_ST_REV : MRC_ST_FWD;
      end
    end else begin
      if (fwd_in && rev_in) begin
        unique case (mode_ff)
          MRC_2W2: nxt_state = first_ff ? MRC_ST_FWD : MRC_ST_REV;
          MRC_2W3: nxt_state = MRC_ST_BRK;
          default: nxt_state = MRC_ST_STOP;
        endcase
      end else if (fwd_in) begin
        nxt_state = MRC_ST_FWD;
      end else if (rev_in) begin
        nxt_state = MRC_ST_REV;
      end else begin
        nxt_state = MRC_ST_STOP;
      end
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff    <= MRC_ST_STOP;
      dir_q_ff    <= 1'b0;
      first_ff    <= 1'b0;
      dir_hold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dir_q_ff <= dir_in;
      if (!fwd_in || !is_3w) begin
        dir_hold_ff <= 1'b0;
      end else if (dir_hit) begin
        dir_hold_ff <= 1'b1;
      end
      if (fwd_in && !rev_in) begin
        first_ff <= 1'b1;
      end else if (rev_in && !fwd_in) begin
        first_ff <= 1'b0;
      end
    end
  end
  assign run_state_o = state_ff;

  ////////////////////////////////////////////////////////////////
  // speed command and ramp unit
  logic [15:0] cmd_speed_ff;
  logic        unit_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_speed_ff <= 16'h0000;
      unit_ff      <= 1'b0;
    end else begin
      cmd_speed_ff <= (speed_sel_ff == 16'h0000) ? speed0_ff : speed_sel_ff;
      unit_ff      <= ctrl_ff[`MRC_CTRL_UNIT_BIT] && mode_ff != MRC_2W3 && mode_ff != MRC_3W3;
    end
  end
  assign cmd_speed_o    = cmd_speed_ff;
  assign unit_per_cmd_o = unit_ff;
  assign filter_sel_o   = filt_ff;

  ////////////////////////////////////////////////////////////////
  // stop holding torque
  logic [7:0] hold_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_ff <= 8'h00;
    end else if (hold_en_ff && state_ff == MRC_ST_STOP && shaft_disp_i >= `MRC_HOLD_DEG10) begin
      hold_ff <= (torque_limit_i <= `MRC_HOLD_PCT) ? torque_limit_i : `MRC_HOLD_PCT;
    end else begin
      hold_ff <= 8'h00;
    end
  end
  assign hold_torque_o = hold_ff;

  ////////////////////////////////////////////////////////////////
  // overload timer: tenths of seconds weighted by load factor
  logic [31:0] tick_ff;
  logic [31:0] acc_ff;
  logic        ovl_ff;
  logic [15:0] ref_load;
  logic        over_lvl;
  assign ref_load = SMALL_DRV ? `MRC_REF_LOAD_SMALL : `MRC_REF_LOAD_LARGE;
  assign over_lvl = load_pct_i > 16'd100;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_ff <= 32'h0;
      acc_ff  <= 32'h0;
      ovl_ff  <= 1'b0;
    end else begin
      if (!over_lvl) begin
        tick_ff <= 32'h0;
        acc_ff  <= 32'h0;
      end else if (tick_ff >= TENTH_CYC - 1) begin
        tick_ff <= 32'h0;
        acc_ff  <= acc_ff + {16'h0, load_pct_i};
      end else begin
        tick_ff <= tick_ff + 32'h1;
      end
      if (acc_ff >= 32'(ovl_time_ff) * 32'(ref_load)) begin
        ovl_ff <= 1'b1;
      end
    end
  end
  assign overload_alarm_o = ovl_ff;

  ////////////////////////////////////////////////////////////////
  // speed reached
  logic        va_ff;
  logic [16:0] diff;
  assign diff = (act_speed_i >= cmd_speed_ff) ? {1'b0, act_speed_i - cmd_speed_ff}
                                              : {1'b0, cmd_speed_ff - act_speed_i};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      va_ff <= 1'b0;
    end else begin
      va_ff <= (state_ff == MRC_ST_FWD || state_ff == MRC_ST_REV) && diff <= {1'b0, va_width_ff};
    end
  end
  assign speed_reached_output_o = va_ff;

  ////////////////////////////////////////////////////////////////
  // register read
  always_comb begin
    prdata_o = 32'h0;
    unique case (paddr_i)
      `MRC_ADDR_CTRL:      prdata_o = ctrl_ff;
      `MRC_ADDR_OVL_TIME:  prdata_o = {16'h0, ovl_time_ff};
      `MRC_ADDR_VA_WIDTH:  prdata_o = {16'h0, va_width_ff};
      `MRC_ADDR_SPEED0:    prdata_o = {16'h0, speed0_ff};
      `MRC_ADDR_SPEED_SEL: prdata_o = {16'h0, speed_sel_ff};
      `MRC_ADDR_STATUS:    prdata_o = {26'h0, va_ff, guard_ff, ovl_ff, hold_en_ff, state_ff};
      `MRC_ADDR_ACT_SPEED: prdata_o = {16'h0, act_speed_i};
      `MRC_ADDR_EFF_CFG:   prdata_o = {26'h0, filt_ff, unit_ff, mode_ff};
      `MRC_ADDR_TORQUE:    prdata_o = {24'h0, hold_ff};
      default:             prdata_o = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // checks
  chk_va_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    va_width_ff >= `MRC_VA_MIN && va_width_ff <= `MRC_VA_MAX) else $error("va width out of range");
  chk_ovl_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovl_time_ff >= `MRC_OVL_MIN && ovl_time_ff <= `MRC_OVL_MAX) else $error("overload time out of range");
  chk_guard_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    guard_ff |=> state_ff == MRC_ST_STOP) else $error("motor ran under start guard");
  chk_run_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!is_3w && !fwd_in && !rev_in) |=> state_ff == MRC_ST_STOP) else $error("motor kept running");
  chk_hold_cap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hold_ff <= `MRC_HOLD_PCT && hold_ff <= $past(torque_limit_i)) else $error("hold torque above cap");
  chk_hold_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (hold_ff != 8'h00) |-> $past(state_ff) == MRC_ST_STOP && $past(hold_en_ff)) else $error("hold while running");
  chk_unit_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($past(mode_ff) == MRC_2W3 || $past(mode_ff) == MRC_3W3) |-> !unit_ff) else $error("unit used in mode 3 or 5");
  chk_va_match: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    va_ff |-> $past(diff) <= {1'b0, $past(va_width_ff)}) else $error("speed reached outside width");
  chk_filt_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(filt_ff) |-> $past(state_ff) == MRC_ST_STOP) else $error("filter changed while running");
  chk_mode_cfg: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(mode_ff) |-> $past(cfg_exec)) else $error("mode changed without configuration");
  chk_arm_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    arming |=> state_ff == MRC_ST_STOP) else $error("motor ran before power-on check");
  chk_guard_free: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (arm_cnt_ff == 3'h3 && !ctrl_ff[`MRC_CTRL_GUARD_BIT]) |=> !guard_ff) else $error("guard set while disabled");
  chk_dir_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (dir_hold_ff && is_3w) |=> (state_ff == MRC_ST_STOP || state_ff == MRC_ST_BRK)) else $error("ran after dir hold");
  chk_brake_3w: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (is_3w && fwd_in && !rev_in && !arming && !guard_hit && !guard_ff && !ovl_ff) |=> state_ff == MRC_ST_BRK)
    else $error("no brake on run/brake low");
  chk_ovl_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovl_ff |=> state_ff == MRC_ST_STOP) else $error("motor ran under overload alarm");
  chk_ovl_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovl_ff |=> ovl_ff) else $error("overload alarm cleared without reset");
endmodule

// >>> dv/mrc_stage_model.sv
`timescale 1ns/1ps
module mrc_stage_model (
  // clock
  input  wire logic                 clk_i,
  // commands from the block
  input  wire mrc_pkg::mrc_state_t  run_state_i,
  input  wire logic [15:0]          cmd_speed_i,
  // feedback to the block
  output logic      [15:0]          act_speed_o,
  output logic      [15:0]          load_pct_o,
  output logic      [15:0]          shaft_disp_o,
  output logic      [7:0]           torque_limit_o
);
  import mrc_pkg::*;
  // knobs set by the bench
  int          spd_ofs;
  logic [15:0] load;
  logic [15:0] disp;
  logic [7:0]  tlim;

  initial begin
    spd_ofs = 0;
    load = 16'h0064;
    disp = 16'h00C8;
    tlim = 8'h64;
  end

  ////////////////////////////////////////////////////////////
  // speed follows command plus offset while turning
  always @(posedge clk_i) begin
    if (run_state_i == MRC_ST_FWD || run_state_i == MRC_ST_REV) begin
      act_speed_o <= 16'(int'(cmd_speed_i) + spd_ofs);
    end else begin
      act_speed_o <= 16'h0000;
    end
    load_pct_o <= load;
    shaft_disp_o <= disp;
    torque_limit_o <= tlim;
  end
endmodule

// >>> dv/motor_run_control_tb_top.sv
`timescale 1ns/1ps
`include "mrc_regs.svh"
module motor_run_control_tb_top;
  import mrc_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        forward_run_input = 1'b1;
  logic        reverse_run_input = 1'b0;
  logic        dir = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  logic [15:0] act;
  logic [15:0] load;
  logic [15:0] disp;
  logic [7:0]  tlim;
  mrc_state_t  st;
  logic [15:0] cmd;
  logic        unit;
  mrc_filt_t   filt;
  logic [7:0]  hold;
  logic        ovl;
  logic        grd;
  logic        va;
  int          mismatches = 0;
  int          tests_run = 0;
  int          prv;
  mrc_state_t  exp_st [6] = '{MRC_ST_STOP, MRC_ST_REV, MRC_ST_FWD, MRC_ST_BRK, MRC_ST_STOP, MRC_ST_BRK};

  always #2.5 clk_i = ~clk_i;

  mrc_run_ctrl #(.TENTH_CYC(10), .SMALL_DRV(1'b1)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .forward_run_input_i(forward_run_input), .reverse_run_input_i(reverse_run_input), .direction_select_input_i(dir),
    .act_speed_i(act), .load_pct_i(load), .shaft_disp_i(disp), .torque_limit_i(tlim),
    .run_state_o(st), .cmd_speed_o(cmd), .unit_per_cmd_o(unit), .filter_sel_o(filt),
    .hold_torque_o(hold), .overload_alarm_o(ovl), .guard_alarm_o(grd), .speed_reached_output_o(va));

  mrc_stage_model stage (
    .clk_i(clk_i), .run_state_i(st), .cmd_speed_i(cmd), .act_speed_o(act),
    .load_pct_o(load), .shaft_disp_o(disp), .torque_limit_o(tlim));

  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(a, 1'b0, 32'h0);
    chk(rd, e, m);
  endtask

  task automatic spd(input int o, input logic e);
    stage.spd_ofs <= o;
    cyc(6);
    chk(32'(va), 32'(e), "speed reached");
  endtask

  task automatic give_verdict;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end

  initial begin
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(6);
    chk(32'(grd), 32'h1, "guard latched");
    chk(32'(st), 32'(MRC_ST_STOP), "guard run");
    rdc(`MRC_ADDR_CTRL, 32'h1, "ctrl reset");
    rdc(`MRC_ADDR_OVL_TIME, 32'h12C, "ovl reset");
    rdc(`MRC_ADDR_VA_WIDTH, 32'hC8, "width reset");
    rdc(`MRC_ADDR_EFF_CFG, 32'h0, "eff reset");
    apb(12'h0FC, 1'b0, 32'h0);
    chk(32'(err), 32'h1, "unmapped");
    forward_run_input <= 1'b0;
    cyc(5);
    chk(32'(grd), 32'h0, "guard clear");
    forward_run_input <= 1'b1;
    cyc(5);
    chk(32'(st), 32'(MRC_ST_FWD), "run");
    $display("test guard done");
    wr(`MRC_ADDR_SPEED0, 32'h5DC);
    cyc(3);
    chk(32'(cmd), 32'h5DC, "entry zero");
    spd(200, 1'b1);
    spd(201, 1'b0);
    spd(-200, 1'b1);
    spd(-201, 1'b0);
    wr(`MRC_ADDR_VA_WIDTH, 32'h32);
    spd(50, 1'b1);
    spd(-51, 1'b0);
    wr(`MRC_ADDR_VA_WIDTH, 32'h0);
    wr(`MRC_ADDR_VA_WIDTH, 32'h191);
    rdc(`MRC_ADDR_VA_WIDTH, 32'h32, "width range");
    wr(`MRC_ADDR_SPEED_SEL, 32'h320);
    cyc(3);
    chk(32'(cmd), 32'h320, "selected");
    wr(`MRC_ADDR_SPEED_SEL, 32'h0);
    cyc(3);
    chk(32'(cmd), 32'h5DC, "unselected");
    forward_run_input <= 1'b0;
    cyc(5);
    chk(32'(st), 32'(MRC_ST_STOP), "stop");
    $display("test speed done");
    prv = 0;
    for (int m = 0; m < 6; m++) begin
      wr(`MRC_ADDR_CTRL, 32'h5 | (32'(m) << 8));
      apb(`MRC_ADDR_EFF_CFG, 1'b0, 32'h0);
      chk(rd & 32'h7, 32'(prv), "mode early");
      wr(`MRC_ADDR_CFG_EXEC, 32'h1);
      apb(`MRC_ADDR_EFF_CFG, 1'b0, 32'h0);
      chk(rd & 32'h7, 32'(m), "mode applied");
      chk(32'(unit), 32'(m != 3 && m != 5), "unit");
      prv = m;
      if (m == 1 || m == 4 || m == 5) begin
        reverse_run_input <= 1'b1;
        forward_run_input <= 1'b1;
        cyc(5);
        chk(32'(st), 32'(MRC_ST_FWD), "3w start");
        dir <= 1'b1;
        cyc(5);
        chk(32'(st), 32'(exp_st[m]), "3w dir");
        reverse_run_input <= 1'b0;
        cyc(5);
        if (m == 1) chk(32'(st), 32'(MRC_ST_BRK), "3w brake");
      end else begin
        forward_run_input <= 1'b1;
        cyc(5);
        reverse_run_input <= 1'b1;
        cyc(5);
        chk(32'(st), 32'(exp_st[m]), "2w both");
      end
      forward_run_input <= 1'b0;
      reverse_run_input <= 1'b0;
      dir <= 1'b0;
      cyc(5);
    end
    $display("test modes done");
    wr(`MRC_ADDR_CTRL, 32'h3);
    cyc(4);
    chk(32'(hold), 32'h0, "hold early");
    wr(`MRC_ADDR_CFG_EXEC, 32'h1);
    cyc(4);
    chk(32'(hold), 32'h32, "hold");
    stage.disp <= 16'h0095;
    cyc(4);
    chk(32'(hold), 32'h0, "hold angle");
    stage.disp <= 16'h0096;
    stage.tlim <= 8'h1E;
    cyc(4);
    chk(32'(hold), 32'h1E, "hold cap");
    prv = 0;
    for (int f = 1; f < 4; f++) begin
      forward_run_input <= 1'b1;
      cyc(5);
      chk(32'(hold), 32'h0, "hold run");
      wr(`MRC_ADDR_CTRL, 32'h3 | (32'(f % 3) << 4));
      cyc(3);
      chk(32'(filt), 32'(prv), "filter early");
      forward_run_input <= 1'b0;
      cyc(6);
      chk(32'(filt), 32'(f % 3), "filter");
      prv = f % 3;
    end
    $display("test hold filter done");
    wr(`MRC_ADDR_OVL_TIME, 32'h0);
    wr(`MRC_ADDR_OVL_TIME, 32'h191);
    rdc(`MRC_ADDR_OVL_TIME, 32'h12C, "ovl range");
    wr(`MRC_ADDR_OVL_TIME, 32'h1);
    cyc(100);
    chk(32'(ovl), 32'h0, "no overload");
    stage.load <= 16'h0096;
    cyc(8);
    chk(32'(ovl), 32'h0, "ovl early");
    cyc(30);
    chk(32'(ovl), 32'h1, "ovl");
    forward_run_input <= 1'b1;
    sys_rst_i <= 1'b1;
    cyc(2);
    chk(32'(st), 32'(MRC_ST_STOP), "power off");
    chk(32'(ovl), 32'h0, "ovl reset");
    $display("test overload done");
    sys_rst_i <= 1'b0;
    wr(`MRC_ADDR_CTRL, 32'h0);
    cyc(5);
    chk(32'(grd), 32'h0, "guard off");
    chk(32'(st), 32'(MRC_ST_FWD), "power-on run");
    $display("test power-on start done");
    give_verdict();
  end
endmodule
